// File: rtl/uef_pkg.sv
package uef_pkg;

  // ****************************************
  // Register field positions, reset values and masks
  // ****************************************
  localparam int          EFC_AUTO_CTS_BIT  = 7;
  localparam int          EFC_AUTO_RTS_BIT  = 6;
  localparam int          EFC_SPECIAL_BIT   = 5;
  localparam int          EFC_ENHANCED_BIT  = 4;
  localparam int          EFC_TX_SEL_HI     = 3;
  localparam int          EFC_TX_SEL_LO     = 2;
  localparam int          EFC_RX_SEL_HI     = 1;
  localparam int          EFC_RX_SEL_LO     = 0;
  localparam int          ISR_SPECIAL_BIT   = 4;
  localparam logic [7:0]  EFC_RESET         = 8'h00;
  localparam logic [7:0]  IER_RESET         = 8'h00;
  localparam logic [7:0]  FCR_RESET         = 8'h00;
  localparam logic [7:0]  MCR_RESET         = 8'h00;
  localparam logic [7:0]  IER_ENH_MASK      = 8'hF0;
  localparam logic [7:0]  ISR_ENH_MASK      = 8'h30;
  localparam logic [7:0]  FCR_ENH_MASK      = 8'h30;
  localparam logic [7:0]  MCR_ENH_MASK      = 8'hE0;
  localparam int          MCR_RTS_BIT       = 1;

  // ****************************************
  // Register select codes
  // ****************************************
  typedef enum logic [2:0] {
    UEF_SEL_EFC = 3'b000,
    UEF_SEL_IER = 3'b001,
    UEF_SEL_ISR = 3'b010,
    UEF_SEL_FCR = 3'b011,
    UEF_SEL_MCR = 3'b100,
    UEF_SEL_CHR = 3'b101
  } uef_sel_t;

  // Flow character selection codes
  typedef enum logic [1:0] {
    UEF_FC_NONE = 2'b00,
    UEF_FC_SECOND = 2'b01,
    UEF_FC_FIRST = 2'b10,
    UEF_FC_BOTH = 2'b11
  } uef_fc_t;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] first_start_char;
    logic [7:0] second_start_char;
    logic [7:0] first_stop_char;
    logic [7:0] second_stop_char;
  } uef_chars_t;

  typedef struct packed {
    logic       hit_start;
    logic       hit_stop;
    logic       hit_special;
  } uef_match_t;

endpackage

// File: rtl/uef_char_match.sv
`timescale 1ns/1ps
`default_nettype none
module uef_char_match
  import uef_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_char_i,
  input  wire logic [1:0] rx_sel_i,
  input  wire logic       special_en_i,
  input  wire uef_chars_t chars_i,
  output var uef_match_t  match_o
);

  // ****************************************
  // Sequence state for two-character patterns
  // ****************************************
  logic       start_half_r;
  logic       start_half_nxt;
  logic       stop_half_r;
  logic       stop_half_nxt;
  uef_match_t match_r;
  uef_match_t match_nxt;

  always_comb begin
    logic h_s1;
    logic h_s2;
    logic h_p1;
    logic h_p2;
    h_s1 = (rx_char_i == chars_i.first_start_char);
    h_s2 = (rx_char_i == chars_i.second_start_char);
    h_p1 = (rx_char_i == chars_i.first_stop_char);
    h_p2 = (rx_char_i == chars_i.second_stop_char);
    start_half_nxt = start_half_r;
    stop_half_nxt  = stop_half_r;
    match_nxt      = '0;
    if (rx_valid_i) begin
      match_nxt.hit_special = special_en_i && h_p2;
      case (rx_sel_i)
        UEF_FC_FIRST: begin
          match_nxt.hit_start = h_s1;
          match_nxt.hit_stop  = h_p1;
        end
        UEF_FC_SECOND: begin
          match_nxt.hit_start = h_s2;
          match_nxt.hit_stop  = h_p2;
        end
        UEF_FC_BOTH: begin
          // Two characters in sequence form one pattern
          match_nxt.hit_start = start_half_r && h_s2;
          match_nxt.hit_stop  = stop_half_r && h_p2;
          start_half_nxt      = h_s1;
          stop_half_nxt       = h_p1;
        end
        default: begin
          start_half_nxt = 1'b0;
          stop_half_nxt  = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      start_half_r <= 1'b0;
      stop_half_r  <= 1'b0;
      match_r      <= '0;
    end else begin
      start_half_r <= start_half_nxt;
      stop_half_r  <= stop_half_nxt;
      match_r      <= match_nxt;
    end
  end

  assign match_o = match_r;

endmodule
`default_nettype wire

// File: rtl/uef_tx_gate.sv
`timescale 1ns/1ps
`default_nettype none
module uef_tx_gate
  import uef_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic auto_cts_i,
  input  wire logic cts_i,
  input  wire logic tx_busy_i,
  output logic      tx_allow_o
);

  // ****************************************
  // Transmit start permission
  // ****************************************
  logic halt_r;
  logic halt_nxt;

  always_comb begin
    halt_nxt = auto_cts_i && cts_i;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      halt_r <= 1'b0;
    end else begin
      halt_r <= halt_nxt;
    end
  end

  // A character in flight is never cut; only new starts are held
  assign tx_allow_o = !halt_r && !tx_busy_i;

endmodule
`default_nettype wire

// File: rtl/uef_top.sv
// Functional notes
// - Auto CTS on (bit 7): CTS high halts transmission.
// - Auto CTS on: transmission resumes when CTS returns low.
// - Bit 7 clear by default: CTS does not gate transmission.
// - Auto RTS on (bit 6): interrupt when RX FIFO reaches trigger level.
// - Auto RTS on: RTS goes high at next trigger level above.
// - Auto RTS on: RTS returns low below programmed level minus one.
// - Flow control off: RTS follows modem control setting only.
// - Special detect (bit 5): match second stop char, store it, set status bit 4.
// - Bit 0 of each character register compares with received LSB.
// - Bit 4 set lets enhanced bits be written; clear holds them latched.
// - Dual mode treats two start and two stop chars as sequences.
// - Low four bits pick software flow combination; reset to zero.
// - Bits 3:2 transmit select, bits 1:0 receive select; 00 disables.
`timescale 1ns/1ps
`default_nettype none
module uef_top
  import uef_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       wr_i,
  input  wire uef_sel_t   sel_i,
  input  wire logic [1:0] chr_idx_i,
  input  wire logic [7:0] wdata_i,
  output logic [7:0]      rdata_o,
  input  wire logic       cts_i,
  input  wire logic       tx_busy_i,
  output logic            tx_allow_o,
  input  wire logic [7:0] rx_level_i,
  input  wire logic [7:0] rx_trig_i,
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_char_i,
  input  wire logic       isr_clr_i,
  output logic            rts_o,
  output logic            rx_trig_irq_o,
  output logic            special_irq_o,
  output logic            rx_store_o,
  output logic            start_seen_o,
  output logic            stop_seen_o,
  output logic [1:0]      tx_char_sel_o,
  output logic [7:0]      ier_o,
  output logic [7:0]      fcr_o,
  output logic [7:0]      mcr_o
);

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] efc_r;
  logic [7:0] efc_nxt;
  logic [7:0] ier_r;
  logic [7:0] ier_nxt;
  logic [7:0] isr_r;
  logic [7:0] isr_nxt;
  logic [7:0] fcr_r;
  logic [7:0] fcr_nxt;
  logic [7:0] mcr_r;
  logic [7:0] mcr_nxt;
  uef_chars_t chars_r;
  uef_chars_t chars_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       enh;
  uef_match_t match;

  assign enh = efc_r[EFC_ENHANCED_BIT];

  // Apply write honouring the enhanced-bit lock
  function automatic logic [7:0] uef_merge(input logic [7:0] cur, input logic [7:0] wd,
                                           input logic [7:0] mask, input logic en);
    logic [7:0] m;
    m = en ? 8'hFF : ~mask;
    return (cur & ~m) | (wd & m);
  endfunction

  always_comb begin
    efc_nxt = efc_r;
    ier_nxt = ier_r;
    fcr_nxt = fcr_r;
    mcr_nxt = mcr_r;
    if (wr_i) begin
      case (sel_i)
        UEF_SEL_EFC: efc_nxt = wdata_i;
        UEF_SEL_IER: ier_nxt = uef_merge(ier_r, wdata_i, IER_ENH_MASK, enh);
        UEF_SEL_FCR: fcr_nxt = uef_merge(fcr_r, wdata_i, FCR_ENH_MASK, enh);
        UEF_SEL_MCR: mcr_nxt = uef_merge(mcr_r, wdata_i, MCR_ENH_MASK, enh);
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      efc_r <= EFC_RESET;
      ier_r <= IER_RESET;
      fcr_r <= FCR_RESET;
      mcr_r <= MCR_RESET;
    end else begin
      efc_r <= efc_nxt;
      ier_r <= ier_nxt;
      fcr_r <= fcr_nxt;
      mcr_r <= mcr_nxt;
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  always_comb begin
    isr_nxt = isr_r;
    if (wr_i && (sel_i == UEF_SEL_ISR)) begin
      isr_nxt = uef_merge(isr_r, wdata_i, ISR_ENH_MASK, enh);
    end
    if (isr_clr_i) begin
      isr_nxt[ISR_SPECIAL_BIT] = 1'b0;
    end
    // Detection wins over a clear in the same cycle
    if (match.hit_special) begin
      isr_nxt[ISR_SPECIAL_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      isr_r <= 8'h00;
    end else begin
      isr_r <= isr_nxt;
    end
  end

  // ****************************************
  // Flow characters
  // ****************************************
  always_comb begin
    chars_nxt = chars_r;
    if (wr_i && (sel_i == UEF_SEL_CHR)) begin
      case (chr_idx_i)
        2'd0: chars_nxt.first_start_char  = wdata_i;
        2'd1: chars_nxt.second_start_char = wdata_i;
        2'd2: chars_nxt.first_stop_char   = wdata_i;
        default: chars_nxt.second_stop_char = wdata_i;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      chars_r <= '0;
    end else begin
      chars_r <= chars_nxt;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    case (sel_i)
      UEF_SEL_EFC: rdata_nxt = efc_r;
      UEF_SEL_IER: rdata_nxt = ier_r;
      UEF_SEL_ISR: rdata_nxt = isr_r;
      UEF_SEL_FCR: rdata_nxt = fcr_r;
      UEF_SEL_MCR: rdata_nxt = mcr_r;
      UEF_SEL_CHR: begin
        case (chr_idx_i)
          2'd0: rdata_nxt = chars_r.first_start_char;
          2'd1: rdata_nxt = chars_r.second_start_char;
          2'd2: rdata_nxt = chars_r.first_stop_char;
          default: rdata_nxt = chars_r.second_stop_char;
        endcase
      end
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // Trigger levels
  // ****************************************
  logic [8:0] trig_eff;
  logic [8:0] trig_hi;
  logic [8:0] trig_lo;

  // Code zero means a level of one
  assign trig_eff = (rx_trig_i == 8'h00) ? 9'd1 : {1'b0, rx_trig_i};
  assign trig_hi  = 9'(trig_eff + 9'd1);
  assign trig_lo  = 9'(trig_eff - 9'd1);

  // ****************************************
  // Receive trigger interrupt
  // ****************************************
  logic       trig_irq_r;
  logic       trig_irq_nxt;

  always_comb begin
    trig_irq_nxt = efc_r[EFC_AUTO_RTS_BIT] && ({1'b0, rx_level_i} >= trig_eff);
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      trig_irq_r <= 1'b0;
    end else begin
      trig_irq_r <= trig_irq_nxt;
    end
  end

  // ****************************************
  // Automatic RTS
  // ****************************************
  logic       rts_hold_r;
  logic       rts_hold_nxt;

  always_comb begin
    rts_hold_nxt = rts_hold_r;
    if (!efc_r[EFC_AUTO_RTS_BIT]) begin
      rts_hold_nxt = 1'b0;
    end else if ({1'b0, rx_level_i} >= trig_hi) begin
      rts_hold_nxt = 1'b1;
    end else if ({1'b0, rx_level_i} < trig_lo) begin
      rts_hold_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rts_hold_r <= 1'b0;
    end else begin
      rts_hold_r <= rts_hold_nxt;
    end
  end

  // ****************************************
  // RTS pin
  // ****************************************
  logic       rts_r;
  logic       rts_nxt;

  always_comb begin
    if (efc_r[EFC_AUTO_RTS_BIT]) begin
      rts_nxt = rts_hold_nxt;
    end else begin
      rts_nxt = mcr_nxt[MCR_RTS_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rts_r <= 1'b0;
    end else begin
      rts_r <= rts_nxt;
    end
  end

  // ****************************************
  // Submodules
  // ****************************************
  uef_tx_gate u_tx_gate (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .auto_cts_i (efc_r[EFC_AUTO_CTS_BIT]),
    .cts_i      (cts_i),
    .tx_busy_i  (tx_busy_i),
    .tx_allow_o (tx_allow_o)
  );

  uef_char_match u_match (
    .clk_i        (clk_i),
    .resetn_i     (resetn_i),
    .rx_valid_i   (rx_valid_i),
    .rx_char_i    (rx_char_i),
    .rx_sel_i     (efc_r[EFC_RX_SEL_HI:EFC_RX_SEL_LO]),
    .special_en_i (efc_r[EFC_SPECIAL_BIT]),
    .chars_i      (chars_r),
    .match_o      (match)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign rdata_o       = rdata_r;
  assign rts_o         = rts_r;
  assign rx_trig_irq_o = trig_irq_r;
  assign special_irq_o = isr_r[ISR_SPECIAL_BIT];
  assign rx_store_o    = match.hit_special;
  assign start_seen_o  = match.hit_start;
  assign stop_seen_o   = match.hit_stop;
  assign tx_char_sel_o = efc_r[EFC_TX_SEL_HI:EFC_TX_SEL_LO];
  assign ier_o         = ier_r;
  assign fcr_o         = fcr_r;
  assign mcr_o         = mcr_r;

endmodule
`default_nettype wire

// File: test/uef_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module uef_monitor
  import uef_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       wr_i,
  input  wire uef_sel_t   sel_i,
  input  wire logic [1:0] chr_idx_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       cts_i,
  input  wire logic       tx_busy_i,
  input  wire logic       tx_allow_o,
  input  wire logic [7:0] rx_level_i,
  input  wire logic [7:0] rx_trig_i,
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_char_i,
  input  wire logic       rts_o,
  input  wire logic       rx_trig_irq_o,
  input  wire logic       special_irq_o,
  input  wire logic       rx_store_o,
  input  wire logic [1:0] tx_char_sel_o,
  input  wire logic [7:0] ier_o,
  input  wire logic [7:0] mcr_o
);
  // ****************************************
  // Mirrors of control and second stop char
  // ****************************************
  logic [7:0] efc_r;
  logic [7:0] efc_nxt;
  logic [7:0] stop2_r;
  logic [7:0] stop2_nxt;
  logic [8:0] trig;
  logic [8:0] lvl;
  always_comb begin
    efc_nxt = efc_r;
    stop2_nxt = stop2_r;
    if (wr_i && sel_i == UEF_SEL_EFC) efc_nxt = wdata_i;
    if (wr_i && sel_i == UEF_SEL_CHR && chr_idx_i == 2'h3) stop2_nxt = wdata_i;
    trig = (rx_trig_i == 8'h00) ? 9'h001 : {1'b0, rx_trig_i};
    lvl = {1'b0, rx_level_i};
  end
  always_ff @(posedge clk_i) begin
    efc_r <= resetn_i ? efc_nxt : 8'h00;
    stop2_r <= resetn_i ? stop2_nxt : 8'h00;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_cts_halt: assert property (efc_r[7] && cts_i |=> !tx_allow_o)
    else $error("tx allowed while cts high");
  chk_cts_resume: assert property (efc_r[7] && !cts_i |=> tx_allow_o == !tx_busy_i)
    else $error("tx not resumed");
  chk_cts_free: assert property (!efc_r[7] |=> tx_allow_o == !tx_busy_i)
    else $error("cts gates tx while auto off");
  chk_trig_irq: assert property (##1 rx_trig_irq_o == $past(efc_r[6] && lvl >= trig))
    else $error("trigger irq wrong");
  chk_rts_raise: assert property (efc_r[6] && lvl > trig |=> rts_o)
    else $error("rts not raised");
  chk_rts_drop: assert property (efc_r[6] && lvl + 9'h001 < trig |=> !rts_o)
    else $error("rts not dropped");
  chk_rts_manual: assert property ((!efc_r[6] && $stable(mcr_o)) [*2] |-> rts_o == mcr_o[1])
    else $error("rts not from modem control");
  chk_special_hit: assert property (efc_r[5] && rx_valid_i && rx_char_i == stop2_r
    |=> rx_store_o ##1 special_irq_o)
    else $error("special char missed");
  chk_enh_lock: assert property (wr_i && sel_i == UEF_SEL_IER && !efc_r[4]
    |=> (ier_o & IER_ENH_MASK) == ($past(ier_o) & IER_ENH_MASK))
    else $error("locked bits changed");
  chk_enh_open: assert property (wr_i && sel_i == UEF_SEL_MCR && efc_r[4] |=> mcr_o == $past(wdata_i))
    else $error("open write lost");
  chk_tx_sel: assert property (tx_char_sel_o == efc_r[3:2])
    else $error("tx select wrong");
endmodule

bind uef_top uef_monitor mon (.clk_i(clk_i), .resetn_i(resetn_i), .wr_i(wr_i), .sel_i(sel_i),
  .chr_idx_i(chr_idx_i), .wdata_i(wdata_i), .cts_i(cts_i), .tx_busy_i(tx_busy_i),
  .tx_allow_o(tx_allow_o), .rx_level_i(rx_level_i), .rx_trig_i(rx_trig_i),
  .rx_valid_i(rx_valid_i), .rx_char_i(rx_char_i), .rts_o(rts_o), .rx_trig_irq_o(rx_trig_irq_o),
  .special_irq_o(special_irq_o), .rx_store_o(rx_store_o), .tx_char_sel_o(tx_char_sel_o),
  .ier_o(ier_o), .mcr_o(mcr_o));
`default_nettype wire

// File: test/uef_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module uef_peer_model (
  input  wire logic  clk_i,
  output logic       cts_o,
  output logic       rx_valid_o,
  output logic [7:0] rx_char_o
);
  // ****************************************
  // Peer serial side
  // ****************************************
  initial begin
    cts_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_char_o = 8'hA5;
  end
  task automatic set_cts(input logic v);
    @(negedge clk_i);
    cts_o = v;
  endtask
  // Characters, flow or data alike, are sent only when asked for
  task automatic send_char(input logic [7:0] c);
    @(negedge clk_i);
    rx_valid_o = 1'b1;
    rx_char_o = c;
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_char_o = ~c;
  endtask
endmodule
`default_nettype wire

// File: test/uef_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module uef_top_tb_top;
  import uef_pkg::*;
  logic clk = 1'b0;
  logic resetn, wr, busy, clr, cts, vld;
  logic tx_allow, rts, irq, sp_irq, store, st_seen, sp_seen;
  logic [7:0] wdata, lvl, trig, rdata, ch, interrupt_enable_reg, fifo_control_reg, modem_control_reg;
  logic [1:0] idx, txsel;
  uef_sel_t sel;
  int error_cnt = 0, num_checks = 0;
  always #25 clk = ~clk;
  uef_peer_model peer (.clk_i(clk), .cts_o(cts), .rx_valid_o(vld), .rx_char_o(ch));
  uef_top dut (.clk_i(clk), .resetn_i(resetn), .wr_i(wr), .sel_i(sel), .chr_idx_i(idx),
    .wdata_i(wdata), .rdata_o(rdata), .cts_i(cts), .tx_busy_i(busy), .tx_allow_o(tx_allow),
    .rx_level_i(lvl), .rx_trig_i(trig), .rx_valid_i(vld), .rx_char_i(ch), .isr_clr_i(clr),
    .rts_o(rts), .rx_trig_irq_o(irq), .special_irq_o(sp_irq), .rx_store_o(store),
    .start_seen_o(st_seen), .stop_seen_o(sp_seen), .tx_char_sel_o(txsel), .ier_o(interrupt_enable_reg),
    .fcr_o(fifo_control_reg), .mcr_o(modem_control_reg));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_reg(input uef_sel_t s, input logic [1:0] i, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    sel = s;
    idx = i;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    for (int s = 0; s < 7; s++) begin
      @(negedge clk);
      sel = uef_sel_t'(s[2:0]);
      @(negedge clk);
      check(rdata, 8'h00);
    end
  endtask
  task automatic t_gate;
    wr_reg(UEF_SEL_IER, 2'h0, 8'hF5);
    check(interrupt_enable_reg, 8'h05);
    wr_reg(UEF_SEL_FCR, 2'h0, 8'h3F);
    check(fifo_control_reg, 8'h0F);
    wr_reg(UEF_SEL_ISR, 2'h0, 8'h10);
    check(sp_irq, 8'h00);
    wr_reg(UEF_SEL_EFC, 2'h0, 8'h10);
    wr_reg(UEF_SEL_IER, 2'h0, 8'hF5);
    check(interrupt_enable_reg, 8'hF5);
    wr_reg(UEF_SEL_FCR, 2'h0, 8'h30);
    check(fifo_control_reg, 8'h30);
    wr_reg(UEF_SEL_ISR, 2'h0, 8'h10);
    check(sp_irq, 8'h01);
    wr_reg(UEF_SEL_ISR, 2'h0, 8'h00);
    check(sp_irq, 8'h00);
    wr_reg(UEF_SEL_MCR, 2'h0, 8'hE0);
    wr_reg(UEF_SEL_EFC, 2'h0, 8'h00);
    wr_reg(UEF_SEL_MCR, 2'h0, 8'h00);
    check(modem_control_reg, 8'hE0);
    sel = UEF_SEL_IER;
    step(1);
    check(rdata, 8'hF5);
  endtask
  task automatic t_cts;
    peer.set_cts(1'b1);
    step(2);
    check(tx_allow, 8'h01);
    wr_reg(UEF_SEL_EFC, 2'h0, 8'h80);
    step(1);
    check(tx_allow, 8'h00);
    busy = 1'b1;
    peer.set_cts(1'b0);
    step(2);
    check(tx_allow, 8'h00);
    busy = 1'b0;
    step(1);
    check(tx_allow, 8'h01);
  endtask
  task automatic t_rts;
    wr_reg(UEF_SEL_EFC, 2'h0, 8'h40);
    lvl = 8'h05;
    step(2);
    check({irq, rts}, 8'h03);
    lvl = 8'h03;
    step(2);
    check({irq, rts}, 8'h01);
    lvl = 8'h02;
    step(2);
    check(rts, 8'h00);
    trig = 8'h00;
    lvl = 8'h01;
    step(2);
    check({irq, rts}, 8'h02);
    lvl = 8'h02;
    step(2);
    check({irq, rts}, 8'h03);
    lvl = 8'h00;
    step(2);
    check({irq, rts}, 8'h01);
    wr_reg(UEF_SEL_EFC, 2'h0, 8'h00);
    wr_reg(UEF_SEL_MCR, 2'h0, 8'h02);
    lvl = 8'h05;
    step(2);
    check({irq, rts}, 8'h01);
    wr_reg(UEF_SEL_MCR, 2'h0, 8'h00);
    check({irq, rts}, 8'h00);
  endtask
  task automatic t_match;
    for (int i = 0; i < 4; i++) wr_reg(UEF_SEL_CHR, i[1:0], 8'h11 + 8'(i));
    step(1);
    check(rdata, 8'h14);
    for (int c = 0; c < 4; c++) begin
      wr_reg(UEF_SEL_EFC, 2'h0, {4'h0, c[1:0], c[1:0]});
      check(txsel, 8'(c));
      peer.send_char(8'h11);
      check(st_seen, 8'(c == 2));
      peer.send_char(8'h13);
      check(sp_seen, 8'(c == 2));
      peer.send_char(8'h14);
      check(sp_seen, 8'(c == 1 || c == 3));
    end
    wr_reg(UEF_SEL_EFC, 2'h0, 8'h20);
    peer.send_char(8'h15);
    check(store, 8'h00);
    peer.send_char(8'h14);
    check(store, 8'h01);
    clr = 1'b1;
    step(1);
    check(sp_irq, 8'h01);
    step(1);
    clr = 1'b0;
    check(sp_irq, 8'h00);
  endtask
  task automatic t_mid_reset;
    resetn = 1'b0;
    step(2);
    resetn = 1'b1;
    t_reset();
  endtask
  initial begin
    resetn = 1'b0;
    wr = 1'b0;
    busy = 1'b0;
    clr = 1'b0;
    wdata = 8'h00;
    lvl = 8'h00;
    trig = 8'h04;
    idx = 2'h0;
    sel = UEF_SEL_EFC;
    step(12);
    resetn = 1'b1;
    t_reset();
    t_gate();
    t_cts();
    t_rts();
    t_match();
    t_mid_reset();
    end_sim();
  end
  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire
